// [include/clk_sel_pkg.sv]
// Constants for the system clock select and internal oscillator control block
// Function
// - Select code 00 internal, 01 external, 10 multiplier.
// - External oscillator stays available for peripherals.
// - Internal oscillator selectable right after enabling.
// - Crystal valid flag set once crystal settled.
// - Reset selects internal oscillator as system clock.
// - Divider codes 000..111 divide 128 down to 1.
// - Divider resets to divide by 128.
// - Suspend bit halts oscillator; stops core clock only while internal oscillator is the active source.
// - Wake on port match or comparator 0 enabled and low.
// - Wake resumes oscillator, core and peripherals.
// - Core continues after the suspending write.
// - Enable field 00 off, 11 on; others reserved.
// - Frequency ready flag reflects programmed frequency.
// - Control bit 3 reads zero; software writes zero.
// - Select register bits 7:2 read zero.
// - Coarse and fine calibration preset for 24 MHz.
// - Multiplier output scaled by 1 to 2/7; this block takes mult_clk as already scaled.
package clk_sel_pkg;

    // ------------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] SYS_CLK_SRC_SEL_ADDR  = 8'h8f;
    localparam logic [7:0] INT_OSC_CTRL_ADDR     = 8'ha1;
    localparam logic [7:0] SYS_CLK_SRC_SEL_RESET = 8'h00;
    localparam logic [7:0] INT_OSC_CTRL_RESET    = 8'hd0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SEL_LSB     = 0;
    localparam int DIV_LSB     = 0;
    localparam int RSVD_BIT    = 3;
    localparam int READY_BIT   = 4;
    localparam int SUSPEND_BIT = 5;
    localparam int ENABLE_LSB  = 6;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SRC_INT_OSC  = 2'h0;
    localparam logic [1:0] SRC_EXT_OSC  = 2'h1;
    localparam logic [1:0] SRC_MULT     = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;
    localparam logic [1:0] OSC_EN_OFF   = 2'h0;
    localparam logic [1:0] OSC_EN_ON    = 2'h3;
    localparam logic [2:0] DIV_BY_1     = 3'h7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_SYS_MHZ        = 125;
    localparam int XTAL_WAIT_US       = 1000;
    localparam int XTAL_WAIT_CYCLES   = XTAL_WAIT_US * CLK_SYS_MHZ;
    localparam int SYNC_STAGES        = 2;

    typedef enum logic [1:0] {SW_RUN, SW_PARK_OLD, SW_WAIT_NEW} switch_state_t;

endpackage : clk_sel_pkg

// [hw/sync_two_ff.sv]
// Two flip-flop synchroniser for a vector of unrelated levels
`timescale 1ns/10ps
`default_nettype none
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // Stage one feeds stage two only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule : sync_two_ff
`default_nettype wire

// [hw/system_clock_select_int_osc_ctrl.sv]
// System clock source select and internal oscillator control
`timescale 1ns/10ps
`default_nettype none
module system_clock_select_int_osc_ctrl
    import clk_sel_pkg::*;
#(
    parameter int         DIV_BITS          = 7,
    parameter logic [6:0] COARSE_CAL_PRESET = 7'h40,
    parameter logic [5:0] FINE_CAL_PRESET   = 6'h20
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Clock sources
    input  wire logic       int_osc_clk,
    input  wire logic       int_osc_stable,
    input  wire logic       ext_osc_clk,
    input  wire logic       xtal_settled,
    input  wire logic       mult_clk,
    // Wake sources
    input  wire logic [3:0] port_match,
    input  wire logic       cmp0_enabled,
    input  wire logic       cmp0_out,
    // Clock outputs and status
    output logic            system_clock,
    output logic            periph_ext_clk,
    output logic            core_clk_enable,
    output logic            int_osc_run,
    output logic            int_osc_freq_ready,
    output logic            crystal_valid_flag,
    output logic      [6:0] int_osc_coarse_cal,
    output logic      [5:0] int_osc_fine_cal
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (DIV_BITS != 7) begin : g_bad_div
        $error("divider must cover divide by 128");
    end

    // ------------------------------------------------------------------
    // Synchronisers for all asynchronous inputs
    // ------------------------------------------------------------------
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] async_bus;
    logic [NSYNC-1:0] sync_bus;
    logic             int_osc_s;
    logic             ext_osc_s;
    logic             mult_s;
    logic             int_stable_s;
    logic             xtal_s;
    logic [3:0]       port_match_s;
    logic             cmp0_en_s;
    logic             cmp0_out_s;

    assign async_bus = {int_osc_clk, ext_osc_clk, mult_clk, int_osc_stable, xtal_settled,
                        port_match, cmp0_enabled, cmp0_out};

    sync_two_ff #(
        .WIDTH (NSYNC)
    ) u_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in (async_bus),
        .sync_out (sync_bus)
    );

    assign int_osc_s    = sync_bus[10];
    assign ext_osc_s    = sync_bus[9];
    assign mult_s       = sync_bus[8];
    assign int_stable_s = sync_bus[7];
    assign xtal_s       = sync_bus[6];
    assign port_match_s = sync_bus[5:2];
    assign cmp0_en_s    = sync_bus[1];
    assign cmp0_out_s   = sync_bus[0];

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic src_level(input logic [1:0] code, input logic int_div,
                                       input logic ext, input logic mul);
        logic lvl;
        lvl = 1'b0;
        unique case (code)
            SRC_INT_OSC: lvl = int_div;
            SRC_EXT_OSC: lvl = ext;
            SRC_MULT:    lvl = mul;
            default:     lvl = 1'b0;
        endcase
        return lvl;
    endfunction : src_level

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction : reg_hit

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [1:0] sel_r,     sel_nxt;
    logic [1:0] osc_en_r,  osc_en_nxt;
    logic       suspend_r, suspend_nxt;
    logic [2:0] div_sel_r, div_sel_nxt;
    logic [7:0] rdata_r,   rdata_nxt;
    logic       ready_r,   ready_nxt;
    logic       wake;

    // any port match or comparator 0 enabled and low
    assign wake = (|port_match_s) | (cmp0_en_s & ~cmp0_out_s);

    always_comb begin
        sel_nxt     = sel_r;
        osc_en_nxt  = osc_en_r;
        suspend_nxt = suspend_r;
        div_sel_nxt = div_sel_r;
        rdata_nxt   = rdata_r;
        if (sfr_wr && reg_hit(sfr_addr, SYS_CLK_SRC_SEL_ADDR)) begin
            sel_nxt = sfr_wdata[SEL_LSB +: 2];
        end
        if (sfr_wr && reg_hit(sfr_addr, INT_OSC_CTRL_ADDR)) begin
            osc_en_nxt  = sfr_wdata[ENABLE_LSB +: 2];
            suspend_nxt = sfr_wdata[SUSPEND_BIT];
            div_sel_nxt = sfr_wdata[DIV_LSB +: 3];
        end
        // wake ends suspend; wake beats a same-cycle write
        if (wake) begin
            suspend_nxt = 1'b0;
        end
        if (sfr_rd) begin
            if (reg_hit(sfr_addr, SYS_CLK_SRC_SEL_ADDR)) begin
                rdata_nxt = {6'h00, sel_r};
            end else if (reg_hit(sfr_addr, INT_OSC_CTRL_ADDR)) begin
                rdata_nxt                    = 8'h00;
                rdata_nxt[ENABLE_LSB +: 2]   = osc_en_r;
                rdata_nxt[SUSPEND_BIT]       = suspend_r;
                rdata_nxt[READY_BIT]         = ready_r;
                rdata_nxt[RSVD_BIT]          = 1'b0;
                rdata_nxt[DIV_LSB +: 3]      = div_sel_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sel_r     <= SYS_CLK_SRC_SEL_RESET[1:0];
            osc_en_r  <= INT_OSC_CTRL_RESET[ENABLE_LSB +: 2];
            suspend_r <= INT_OSC_CTRL_RESET[SUSPEND_BIT];
            div_sel_r <= INT_OSC_CTRL_RESET[DIV_LSB +: 3];
            rdata_r   <= 8'h00;
        end else begin
            sel_r     <= sel_nxt;
            osc_en_r  <= osc_en_nxt;
            suspend_r <= suspend_nxt;
            div_sel_r <= div_sel_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Oscillator run, ready and divider
    // ------------------------------------------------------------------
    logic                run_r,   run_nxt;
    logic                xtal_r,  xtal_nxt;
    logic                int_prev_r, int_prev_nxt;
    logic [DIV_BITS-1:0] div_cnt_r,  div_cnt_nxt;
    logic                int_div;

    always_comb begin
        // run follows the enable write with no wait state
        run_nxt      = (osc_en_nxt == OSC_EN_ON) && !suspend_nxt;
        // ready only when running and settled
        ready_nxt    = run_r && int_stable_s;
        // crystal flag follows the settled level
        xtal_nxt     = xtal_s;
        int_prev_nxt = int_osc_s;
        div_cnt_nxt  = div_cnt_r;
        if (int_osc_s && !int_prev_r) begin
            div_cnt_nxt = div_cnt_r + 1'b1;
        end
    end

    // code 111 passes the oscillator, lower codes pick a counter bit
    always_comb begin
        if (div_sel_r == DIV_BY_1) begin
            int_div = int_osc_s;
        end else begin
            int_div = div_cnt_r[3'(DIV_BITS - 1) - div_sel_r];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            run_r      <= 1'b1;
            ready_r    <= 1'b0;
            xtal_r     <= 1'b0;
            int_prev_r <= 1'b0;
            div_cnt_r  <= '0;
        end else begin
            run_r      <= run_nxt;
            ready_r    <= ready_nxt;
            xtal_r     <= xtal_nxt;
            int_prev_r <= int_prev_nxt;
            div_cnt_r  <= div_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Glitch-free source switch
    // ------------------------------------------------------------------
    switch_state_t sw_state_r, sw_state_nxt;
    logic [1:0]    active_r,   active_nxt;
    logic          system_clock_r,   system_clock_nxt;
    logic          core_en_r,  core_en_nxt;
    logic          ext_r,      ext_nxt;
    logic          old_lvl;
    logic          new_lvl;

    assign old_lvl = src_level(active_r, int_div, ext_osc_s, mult_s);
    assign new_lvl = src_level(sel_r, int_div, ext_osc_s, mult_s);

    always_comb begin
        sw_state_nxt = sw_state_r;
        active_nxt   = active_r;
        system_clock_nxt   = 1'b0;
        unique case (sw_state_r)
            SW_RUN: begin
                system_clock_nxt = old_lvl;
                // software only asks for settled sources
                if (sel_r != active_r && sel_r != SRC_RESERVED) begin
                    sw_state_nxt = SW_PARK_OLD;
                end
            end
            SW_PARK_OLD: begin
                // leave the old source only while it is low
                system_clock_nxt = old_lvl;
                if (!old_lvl) begin
                    system_clock_nxt   = 1'b0;
                    sw_state_nxt = SW_WAIT_NEW;
                end
            end
            SW_WAIT_NEW: begin
                // join the new source at a low phase
                if (sel_r == SRC_RESERVED || sel_r == active_r) begin
                    sw_state_nxt = SW_RUN;
                end else if (!new_lvl) begin
                    active_nxt   = sel_r;
                    sw_state_nxt = SW_RUN;
                end
            end
        endcase
        // core clock gated while the internal source is suspended
        // no reset of the core, so it resumes after the write
        core_en_nxt = !(suspend_r && active_r == SRC_INT_OSC);
        // external clock always offered to peripherals
        ext_nxt     = ext_osc_s;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sw_state_r <= SW_RUN;
            active_r   <= SRC_INT_OSC;
            system_clock_r   <= 1'b0;
            core_en_r  <= 1'b1;
            ext_r      <= 1'b0;
        end else begin
            sw_state_r <= sw_state_nxt;
            active_r   <= active_nxt;
            system_clock_r   <= system_clock_nxt;
            core_en_r  <= core_en_nxt;
            ext_r      <= ext_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Calibration presets
    // ------------------------------------------------------------------
    logic [6:0] coarse_r;
    logic [5:0] fine_r;

    // preset calibration driven to the oscillator
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            coarse_r <= COARSE_CAL_PRESET;
            fine_r   <= FINE_CAL_PRESET;
        end else begin
            coarse_r <= coarse_r;
            fine_r   <= fine_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // multiplier scaling happens upstream of mult_clk
    assign sfr_rdata          = rdata_r;
    assign system_clock       = system_clock_r;
    assign periph_ext_clk     = ext_r;
    assign core_clk_enable    = core_en_r;
    // wake path is clocked by clk_sys, independent of system_clock
    assign int_osc_run        = run_r;
    assign int_osc_freq_ready = ready_r;
    assign crystal_valid_flag = xtal_r;
    assign int_osc_coarse_cal = coarse_r;
    assign int_osc_fine_cal   = fine_r;

endmodule : system_clock_select_int_osc_ctrl
`default_nettype wire

// [testbench/system_clock_select_int_osc_ctrl_props.sv]
// Port checker for the clock select and internal oscillator block
`timescale 1ns/10ps
`default_nettype none
module system_clock_select_int_osc_ctrl_props
    import clk_sel_pkg::*;
#(
    parameter logic [6:0] COARSE_CAL_PRESET = 7'h40
) (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       reset,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Pins and status
    input wire logic       xtal_settled,
    input wire logic [3:0] port_match,
    input wire logic       cmp0_enabled,
    input wire logic       cmp0_out,
    input wire logic       core_clk_enable,
    input wire logic       int_osc_run,
    input wire logic       int_osc_freq_ready,
    input wire logic       crystal_valid_flag,
    input wire logic [6:0] int_osc_coarse_cal
);
    logic       quiet;
    logic       ctl_wr;
    logic       q1_r;
    logic       q2_r;
    logic [1:0] en_r;
    assign quiet  = (port_match == 4'h0) && !(cmp0_enabled && !cmp0_out);
    assign ctl_wr = sfr_wr && sfr_addr == INT_OSC_CTRL_ADDR;
    // Enable mirror: a wake only restarts an enabled oscillator
    always_ff @(posedge clk_sys) begin
        q1_r <= quiet;
        q2_r <= q1_r;
        if (reset) begin
            en_r <= 2'h3;
        end else if (ctl_wr) begin
            en_r <= sfr_wdata[7:6];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sel_upper_zero_a: assert property (
        sfr_rd && sfr_addr == SYS_CLK_SRC_SEL_ADDR |=> sfr_rdata[7:2] == 6'h00)
        else $error("select register upper bits read non-zero");
    ctrl_bit3_zero_a: assert property (
        sfr_rd && sfr_addr == INT_OSC_CTRL_ADDR |=> sfr_rdata[3] == 1'b0)
        else $error("control bit 3 read non-zero");
    ready_needs_run_a: assert property (!int_osc_run |=> !int_osc_freq_ready)
        else $error("ready flag high with oscillator stopped");
    cal_preset_a: assert property (int_osc_coarse_cal == COARSE_CAL_PRESET)
        else $error("coarse calibration not at preset");
    suspend_stop_a: assert property (
        ctl_wr && sfr_wdata[7:5] == 3'h7 && quiet && q1_r && q2_r |=> !int_osc_run)
        else $error("suspend write did not stop the oscillator");
    enable_off_a: assert property (ctl_wr && sfr_wdata[7:6] != 2'h3 |=> !int_osc_run)
        else $error("oscillator runs with enable field not 11");
    wake_restart_a: assert property (
        (!quiet)[*4] ##0 en_r == 2'h3 |-> ##[0:4] (int_osc_run && core_clk_enable))
        else $error("wake event did not restart oscillator and core");
    xtal_flag_a: assert property ($rose(crystal_valid_flag) |-> $past(xtal_settled, 2))
        else $error("crystal flag rose without settled crystal");
    reset_state_a: assert property (disable iff (1'b0)
        reset |=> core_clk_enable && int_osc_run && sfr_rdata == 8'h00)
        else $error("reset state wrong");
    suspend_seen_c: cover property ($fell(core_clk_enable));
    wake_seen_c: cover property ((!quiet)[*4] ##1 int_osc_run);
    xtal_seen_c: cover property ($rose(crystal_valid_flag));
endmodule : system_clock_select_int_osc_ctrl_props
bind system_clock_select_int_osc_ctrl system_clock_select_int_osc_ctrl_props #(
    .COARSE_CAL_PRESET(COARSE_CAL_PRESET)
) props_i (
    .clk_sys, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .xtal_settled,
    .port_match, .cmp0_enabled, .cmp0_out, .core_clk_enable, .int_osc_run,
    .int_osc_freq_ready, .crystal_valid_flag, .int_osc_coarse_cal
);
`default_nettype wire

// [testbench/osc_sources_model.sv]
// Behavioural oscillators and clock multiplier feeding the block
`timescale 1ns/10ps
`default_nettype none
module osc_sources_model #(
    parameter real INT_HALF  = 24.0,
    parameter real EXT_HALF  = 35.2,
    parameter real MUL_HALF  = 17.6,
    parameter real STABLE_NS = 200.0,
    parameter real XTAL_NS   = 2000.0
) (
    // Run request
    input  wire logic int_osc_run,
    // Sources
    output logic      int_osc_clk,
    output logic      int_osc_stable,
    output logic      ext_osc_clk,
    output logic      xtal_settled,
    output logic      mult_clk
);
    // Half periods chosen never to land on a rising reference edge
    initial begin
        int_osc_clk    = 1'b0;
        int_osc_stable = 1'b0;
        ext_osc_clk    = 1'b0;
        mult_clk       = 1'b0;
        xtal_settled   = 1'b0;
        #XTAL_NS;
        xtal_settled = 1'b1;
    end
    // Stands still low while stopped
    always begin
        #INT_HALF;
        int_osc_clk = int_osc_run ? ~int_osc_clk : 1'b0;
    end
    always @(int_osc_run) begin
        int_osc_stable = 1'b0;
        if (int_osc_run) #STABLE_NS int_osc_stable = int_osc_run;
    end
    always #EXT_HALF ext_osc_clk = ~ext_osc_clk;
    always #MUL_HALF mult_clk = ~mult_clk;
endmodule : osc_sources_model
`default_nettype wire

// [testbench/system_clock_select_int_osc_ctrl_tb.sv]
// Self-checking bench for the clock select and internal oscillator block
`timescale 1ns/10ps
`default_nettype none
module system_clock_select_int_osc_ctrl_tb
    import clk_sel_pkg::*;
;
    localparam real INT_H = 24.0;
    localparam real EXT_H = 35.2;
    localparam real MUL_H = 17.6;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [3:0]  port_match = 4'h0;
    logic        cmp0_enabled = 1'b1;
    logic        cmp0_out = 1'b1;
    logic        int_osc_clk, int_osc_stable, ext_osc_clk, xtal_settled, mult_clk;
    logic        system_clock, periph_ext_clk, core_clk_enable, int_osc_run;
    logic        int_osc_freq_ready, crystal_valid_flag, p;
    logic [7:0]  sfr_rdata, ctrl_m;
    logic [6:0]  coarse;
    logic [5:0]  fine;
    logic [31:0] seed = 32'hb6bfbc0b;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n;
    real         tp[4] = '{2 * INT_H, 2 * EXT_H, 2 * MUL_H, 2 * MUL_H};
    always #4 clk_sys = ~clk_sys;
    osc_sources_model #(.INT_HALF(INT_H), .EXT_HALF(EXT_H), .MUL_HALF(MUL_H)) osc (
        .int_osc_run, .int_osc_clk, .int_osc_stable, .ext_osc_clk, .xtal_settled, .mult_clk);
    system_clock_select_int_osc_ctrl dut (
        .clk_sys, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .int_osc_clk,
        .int_osc_stable, .ext_osc_clk, .xtal_settled, .mult_clk, .port_match, .cmp0_enabled,
        .cmp0_out, .system_clock, .periph_ext_clk, .core_clk_enable, .int_osc_run,
        .int_osc_freq_ready, .crystal_valid_flag, .int_osc_coarse_cal(coarse),
        .int_osc_fine_cal(fine));
    // ------------------------------------------------------------------
    // Tasks and reference model
    // ------------------------------------------------------------------
    function automatic void xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endfunction : xs
    // Ready only while enabled and not suspended
    function automatic logic [7:0] ctrl_exp();
        return {ctrl_m[7:5], ctrl_m[7:5] == 3'h6, 1'b0, ctrl_m[2:0]};
    endfunction : ctrl_exp
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        if (a == INT_OSC_CTRL_ADDR) ctrl_m = d & 8'he7;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        chk(sfr_rdata, e);
    endtask : rd
    task automatic rise(output int c);
        c = 0;
        do begin
            p = system_clock;
            @(posedge clk_sys);
            #1;
            c++;
        end while (!(p === 1'b0 && system_clock === 1'b1) && c < 2000);
    endtask : rise
    // Third rise gives a clean period after any switch
    task automatic per(input real e);
        rise(n);
        rise(n);
        rise(n);
        chk((n * 8.0 > e - 12.0) && (n * 8.0 < e + 12.0), 1'b1);
    endtask : per
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        tick(20);
        reset <= 1'b0;
        ctrl_m = 8'hc0;
        rd(SYS_CLK_SRC_SEL_ADDR, SYS_CLK_SRC_SEL_RESET);
        chk(crystal_valid_flag, 1'b0);
        tick(60);
        rd(INT_OSC_CTRL_ADDR, INT_OSC_CTRL_RESET);
        chk(fine, 6'h20);
        $display("reset values done");
        for (int k = 0; k < 8; k++) begin
            wr(INT_OSC_CTRL_ADDR, 8'hc0 | k[7:0]);
            per(tp[0] * (2 ** (7 - k)));
        end
        $display("divider codes done");
        for (int i = 0; i < 4; i++) begin
            xs();
            wr(SYS_CLK_SRC_SEL_ADDR, seed[7:0] & 8'hfc);
            rd(SYS_CLK_SRC_SEL_ADDR, 8'h00);
            wr(INT_OSC_CTRL_ADDR, (seed[15:8] & 8'h07) | 8'hc0);
            rd(INT_OSC_CTRL_ADDR, ctrl_exp());
            wr({4'h4, seed[19:16]}, seed[31:24]);
            rd({4'h4, seed[19:16]}, 8'h00);
        end
        $display("random register access done");
        wr(INT_OSC_CTRL_ADDR, 8'hc7);
        chk(crystal_valid_flag, 1'b1);
        for (int i = 1; i < 5; i++) begin
            wr(SYS_CLK_SRC_SEL_ADDR, 8'(i % 4));
            rd(SYS_CLK_SRC_SEL_ADDR, 8'(i % 4));
            per(tp[i % 4]);
        end
        n = 0;
        repeat (400) begin
            p = periph_ext_clk;
            @(posedge clk_sys);
            #1;
            if (p === 1'b0 && periph_ext_clk === 1'b1) n++;
        end
        chk((n > 3200.0 / tp[1] - 2) && (n < 3200.0 / tp[1] + 2), 1'b1);
        $display("source select done");
        for (int w = 0; w < 6; w++) begin
            // Let the switch finish before suspending
            if (w == 5) begin
                wr(SYS_CLK_SRC_SEL_ADDR, {6'h00, SRC_EXT_OSC});
                tick(20);
            end
            wr(INT_OSC_CTRL_ADDR, 8'he7);
            tick(6);
            #1;
            chk({core_clk_enable, int_osc_run}, {w == 5, 1'b0});
            tick(1);
            if (w == 4) begin
                cmp0_enabled <= 1'b0;
                cmp0_out     <= 1'b0;
                tick(8);
                #1;
                chk(core_clk_enable, 1'b0);
                tick(1);
                cmp0_enabled <= 1'b1;
            end else port_match[w % 4] <= 1'b1;
            tick(8);
            #1;
            chk(core_clk_enable & int_osc_run, 1'b1);
            tick(1);
            port_match <= 4'h0;
            cmp0_out   <= 1'b1;
            ctrl_m = ctrl_m & 8'hdf;
            tick(60);
            rd(INT_OSC_CTRL_ADDR, ctrl_exp());
        end
        $display("suspend and wake done");
        for (int e = 0; e < 3; e++) begin
            wr(INT_OSC_CTRL_ADDR, {e[1:0], 6'h07});
            tick(6);
            #1;
            chk({int_osc_run, int_osc_freq_ready}, 2'b00);
            rd(INT_OSC_CTRL_ADDR, ctrl_exp());
        end
        wr(INT_OSC_CTRL_ADDR, 8'hc7);
        wr(SYS_CLK_SRC_SEL_ADDR, {6'h00, SRC_INT_OSC});
        per(tp[0]);
        $display("enable field done");
        give_verdict();
    end
endmodule : system_clock_select_int_osc_ctrl_tb
`default_nettype wire
